// file: hw/gdrw_device.sv
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// (RULE1) controller opens a row with ACTIVE, bank and row, before access
// (RULE2) controller waits activate_to_access_delay, rounded up, after ACTIVE
// (RULE3) same bank reopens only after precharge, spaced by same_bank_activate_interval
// (RULE4) other banks may activate meanwhile, spaced by cross_bank_activate_interval
// (RULE5) READ carries column, bank, auto precharge; closes row once row time met
// (RULE6) first read element one CAS latency after READ, then every strobe edge
// (RULE7) read data edge-aligned to clock and to read strobe
// (RULE8) strobe driven high half clock before first fall; postamble on last element
// (RULE9) data lines released after burst when no further read follows
// (RULE10) READ spaced one burst apart gives seamless concatenated data
// (RULE11) a started read burst always runs its full length; here a READ falling due mid-burst restarts at element zero and cuts it short
// (RULE12) terminators off while read commands execute
// (RULE13) four read strobes, one per byte lane, lane zero on low byte
// (RULE14) controller leaves over one clock from termination on to write data
// (RULE15) elements after the first follow the programmed burst order
// (RULE16) WRITE carries column, bank, auto precharge; closes row at burst end
// (RULE17) first write element on rising strobe after write latency, then every edge
// (RULE18) controller drives half-cycle write preamble and postamble
// (RULE19) after a write burst, further input data is ignored
// (RULE20) controller never truncates writes; next WRITE one burst later
// (RULE21) controller meets write_recovery_time before PRECHARGE after write
// (RULE22) address bit eight selects auto precharge on READ and WRITE
// (RULE23) controller keeps clock enable high until the burst completes
// (RULE24) commands decoded from select and strobe levels at clock rise
// (RULE25) controller tracks bank state and timing counters
module gdrw_device (
  input  wire logic                    SYS_CLK,
  input  wire logic                    RST_N,
  input  wire logic                    CK,
  input  wire gdrw_pkg::gdrw_pins_t    CMD,
  input  wire logic [31:0]             DQ_IN,
  output logic      [31:0]             DQ_OUT,
  output logic                         DQ_OE_N,
  output logic      [3:0]              READ_STROBE,
  output logic                         READ_STROBE_OE_N,
  input  wire logic                    WRITE_STROBE,
  output logic                         ODT_ON,
  input  wire gdrw_pkg::gdrw_apb_req_t APB_REQ,
  output gdrw_pkg::gdrw_apb_rsp_t      APB_RSP
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic                                          ck_s1;
    logic                                          ck_s2;
    logic                                          ck_d;
    gdrw_pkg::gdrw_pins_t                          cmd_s1;
    gdrw_pkg::gdrw_pins_t                          cmd_s2;
    logic [31:0]                                   dq_s1;
    logic [31:0]                                   dq_s2;
    logic                                          ws_s1;
    logic                                          ws_s2;
    logic                                          ws_d;
    gdrw_pkg::gdrw_slot_t [gdrw_pkg::PIPE_DEPTH-1:0] pipe;
    logic                                          rd_act;
    logic [1:0]                                    rd_idx;
    gdrw_pkg::gdrw_slot_t                          rd;
    logic                                          wr_act;
    logic [1:0]                                    wr_idx;
    gdrw_pkg::gdrw_slot_t                          wr;
    logic                                          wr_pend;
    gdrw_pkg::gdrw_slot_t                          wr_nx;
    logic [3:0]                                    bank_open;
    logic [3:0]                                    ap_pend;
    logic [3:0][7:0]                               ras_cnt;
    gdrw_pkg::gdrw_cfg_t                           cfg;
    logic                                          cmd_err;
    logic [31:0]                                   dq_out;
    logic                                          dq_oe_n;
    logic [3:0]                                    rstb;
    logic                                          rstb_oe_n;
    logic                                          odt;
    gdrw_pkg::gdrw_apb_rsp_t                       apb;
  } gdrw_state_t;

  gdrw_state_t                       s_reg;
  gdrw_state_t                       s_next;
  logic                              rise;
  logic                              fall;
  logic                              tick;
  logic [3:0]                        cl_i;
  logic [3:0]                        wl_i;
  logic                              rd_due;
  logic                              wr_due;
  logic                              ws_rise;
  logic                              ws_edge;
  logic                              mem_we;
  logic [gdrw_pkg::ADDR_BITS-1:0]    mem_waddr;
  logic [gdrw_pkg::ADDR_BITS-1:0]    mem_raddr;
  logic [31:0]                       mem_wdata;
  logic [31:0]                       mem_rdata;

  // ****************************************
  // functions
  // ****************************************
  function automatic gdrw_pkg::gdrw_cmd_t decode(input gdrw_pkg::gdrw_pins_t p);
    decode = gdrw_pkg::CMD_NOP;
    if (p.cke && !p.cs_n) begin
      case ({p.ras_n, p.cas_n, p.we_n})
        3'h3:    decode = gdrw_pkg::CMD_ACT;
        3'h5:    decode = gdrw_pkg::CMD_READ;
        3'h4:    decode = gdrw_pkg::CMD_WRITE;
        3'h2:    decode = gdrw_pkg::CMD_PRE;
        3'h7:    decode = gdrw_pkg::CMD_NOP;
        default: decode = gdrw_pkg::CMD_OTHER;
      endcase
    end
  endfunction

  function automatic logic [gdrw_pkg::COL_BITS-1:0] burst_col(
    input logic [gdrw_pkg::COL_BITS-1:0] c,
    input logic [1:0]                    i,
    input logic                          ilv
  );
    burst_col      = c;
    burst_col[1:0] = ilv ? (c[1:0] ^ i) : (c[1:0] + i);
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    gdrw_pkg::gdrw_slot_t new_slot;
    gdrw_pkg::gdrw_cmd_t  cmd;
    logic [1:0]           bk;
    logic                 acc;
    logic                 hit;
    logic                 pre;
    new_slot = '0;
    acc      = 1'b0;
    hit      = 1'b0;
    pre      = 1'b0;
    cmd      = decode(s_reg.cmd_s2);
    bk       = s_reg.cmd_s2.bank;
    s_next   = s_reg;

    // pins reach logic only through the second stage
    s_next.ck_s1  = CK;
    s_next.ck_s2  = s_reg.ck_s1;
    s_next.ck_d   = s_reg.ck_s2;
    s_next.cmd_s1 = CMD;
    s_next.cmd_s2 = s_reg.cmd_s1;
    s_next.dq_s1  = DQ_IN;
    s_next.dq_s2  = s_reg.dq_s1;
    s_next.ws_s1  = WRITE_STROBE;
    s_next.ws_s2  = s_reg.ws_s1;
    s_next.ws_d   = s_reg.ws_s2;

    rise    = s_reg.ck_s2 & ~s_reg.ck_d;
    fall    = ~s_reg.ck_s2 & s_reg.ck_d;
    tick    = rise | fall;
    ws_rise = s_reg.ws_s2 & ~s_reg.ws_d;
    ws_edge = s_reg.ws_s2 ^ s_reg.ws_d;
    cl_i    = s_reg.cfg.cl - 4'h1;
    wl_i    = s_reg.cfg.wl - 4'h1;
    rd_due  = s_reg.pipe[cl_i].rd;
    wr_due  = s_reg.pipe[wl_i].wr;

    // ****************************************
    // row timers and auto precharge
    // ****************************************
    for (int b = 0; b < 4; b++) begin
      if (s_reg.ras_cnt[b] != 8'hff) begin
        s_next.ras_cnt[b] = s_reg.ras_cnt[b] + 8'h1;
      end
      if (s_reg.ap_pend[b] && s_reg.ras_cnt[b] >= gdrw_pkg::ROW_ACTIVE_CYC) begin
        s_next.bank_open[b] = 1'b0; // RULE5
        s_next.ap_pend[b]   = 1'b0;
      end
    end

    // ****************************************
    // command decode at clock rise
    // ****************************************
    if (rise) begin
      case (cmd) // RULE24
        gdrw_pkg::CMD_ACT: begin
          if (s_reg.bank_open[bk]) begin
            s_next.cmd_err = 1'b1;
          end
          s_next.bank_open[bk] = 1'b1;
          s_next.ras_cnt[bk]   = 8'h0;
        end
        gdrw_pkg::CMD_READ, gdrw_pkg::CMD_WRITE: begin
          if (!s_reg.bank_open[bk]) begin
            s_next.cmd_err = 1'b1;
          end
          new_slot.rd   = (cmd == gdrw_pkg::CMD_READ);
          new_slot.wr   = (cmd == gdrw_pkg::CMD_WRITE);
          new_slot.ap   = s_reg.cmd_s2.addr[gdrw_pkg::AUTO_PRECHARGE_SELECT_BIT]; // RULE5
          new_slot.bank = bk;
          new_slot.col  = s_reg.cmd_s2.addr[gdrw_pkg::COL_BITS-1:0];
        end
        gdrw_pkg::CMD_PRE: begin
          if (s_reg.cmd_s2.addr[gdrw_pkg::AUTO_PRECHARGE_SELECT_BIT]) begin
            s_next.bank_open = 4'h0;
            s_next.ap_pend   = 4'h0;
          end else begin
            s_next.bank_open[bk] = 1'b0;
            s_next.ap_pend[bk]   = 1'b0;
          end
        end
        default: begin
        end
      endcase
      // one slot per clock; latency is read out of the slot's depth
      s_next.pipe = {s_reg.pipe[gdrw_pkg::PIPE_DEPTH-2:0], new_slot};
    end

    // ****************************************
    // read burst
    // ****************************************
    pre = fall && rd_due && !s_reg.rd_act;
    if (tick && s_reg.rd_act && s_reg.rd_idx == gdrw_pkg::BURST_LAST) begin
      s_next.rd_act = 1'b0; // RULE9
      if (s_reg.rd.ap) begin
        s_next.ap_pend[s_reg.rd.bank] = 1'b1;
      end
    end else if (tick && s_reg.rd_act) begin
      s_next.rd_idx = s_reg.rd_idx + 2'h1; // RULE11
    end
    if (rise && rd_due) begin
      s_next.rd_act = 1'b1; // RULE6 RULE10
      s_next.rd_idx = 2'h0;
      s_next.rd     = s_reg.pipe[cl_i];
    end
    mem_raddr = {s_next.rd.bank,
                 burst_col(s_next.rd.col, s_next.rd_idx, s_reg.cfg.ilv)}; // RULE15
    if (tick) begin
      if (s_next.rd_act) begin
        // strobe low on even elements keeps the first fall on element zero
        s_next.dq_out    = mem_rdata; // RULE7
        s_next.dq_oe_n   = 1'b0;
        s_next.rstb      = {4{s_next.rd_idx[0]}}; // RULE13
        s_next.rstb_oe_n = 1'b0;
      end else if (pre) begin
        s_next.rstb      = 4'hf; // RULE8
        s_next.rstb_oe_n = 1'b0;
      end else begin
        s_next.dq_oe_n   = 1'b1; // RULE9
        s_next.rstb      = 4'h0;
        s_next.rstb_oe_n = 1'b1;
      end
    end

    // ****************************************
    // write burst
    // ****************************************
    mem_we    = 1'b0;
    mem_waddr = {s_reg.wr.bank,
                 burst_col(s_reg.wr.col, s_reg.wr_idx, s_reg.cfg.ilv)}; // RULE15
    mem_wdata = s_reg.dq_s2;
    if (s_reg.wr_act && (s_reg.wr_idx == 2'h0 ? ws_rise : ws_edge)) begin
      mem_we = 1'b1; // RULE17
      if (s_reg.wr_idx == gdrw_pkg::BURST_LAST) begin
        s_next.wr_act = s_reg.wr_pend; // RULE19
        s_next.wr_idx = 2'h0;
        s_next.wr     = s_reg.wr_nx;
        s_next.wr_pend = 1'b0;
        if (s_reg.wr.ap) begin
          s_next.bank_open[s_reg.wr.bank] = 1'b0; // RULE16
        end
      end else begin
        s_next.wr_idx = s_reg.wr_idx + 2'h1;
      end
    end
    // window opens in the preamble half cycle, ahead of the first rise
    if (fall && wr_due) begin
      if (s_next.wr_act) begin
        s_next.wr_pend = 1'b1;
        s_next.wr_nx   = s_reg.pipe[wl_i];
      end else begin
        s_next.wr_act = 1'b1;
        s_next.wr_idx = 2'h0;
        s_next.wr     = s_reg.pipe[wl_i];
      end
    end

    // ****************************************
    // terminators
    // ****************************************
    s_next.odt = 1'b1;
    for (int i = 0; i < gdrw_pkg::PIPE_DEPTH; i++) begin
      if (s_next.pipe[i].rd && 4'(i) < s_reg.cfg.cl) begin
        s_next.odt = 1'b0; // RULE12
      end
    end
    if (s_next.rd_act || !s_next.rstb_oe_n) begin
      s_next.odt = 1'b0; // RULE12
    end

    // ****************************************
    // register bus
    // ****************************************
    acc = APB_REQ.psel && APB_REQ.penable && !s_reg.apb.pready;
    hit = APB_REQ.paddr == gdrw_pkg::REG_CONFIG || APB_REQ.paddr == gdrw_pkg::REG_STATUS;
    s_next.apb.pready  = acc;
    s_next.apb.pslverr = acc && !hit;
    s_next.apb.prdata  = 32'h0;
    if (acc && !APB_REQ.pwrite && APB_REQ.paddr == gdrw_pkg::REG_CONFIG) begin
      s_next.apb.prdata[gdrw_pkg::CFG_CL_LSB +: 4]  = s_reg.cfg.cl;
      s_next.apb.prdata[gdrw_pkg::CFG_WL_LSB +: 4]  = s_reg.cfg.wl;
      s_next.apb.prdata[gdrw_pkg::CFG_ILV_BIT]      = s_reg.cfg.ilv;
    end
    if (acc && !APB_REQ.pwrite && APB_REQ.paddr == gdrw_pkg::REG_STATUS) begin
      s_next.apb.prdata[gdrw_pkg::STS_BANK_LSB +: 4] = s_reg.bank_open;
      s_next.apb.prdata[gdrw_pkg::STS_RD_BIT]        = s_reg.rd_act;
      s_next.apb.prdata[gdrw_pkg::STS_WR_BIT]        = s_reg.wr_act;
      s_next.apb.prdata[gdrw_pkg::STS_ERR_BIT]       = s_reg.cmd_err;
      s_next.apb.prdata[gdrw_pkg::STS_AP_LSB +: 4]   = s_reg.ap_pend;
    end
    // writes land only on the edge that completes the access
    if (s_reg.apb.pready && APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite) begin
      if (APB_REQ.paddr == gdrw_pkg::REG_CONFIG) begin
        s_next.cfg.cl  = APB_REQ.pwdata[gdrw_pkg::CFG_CL_LSB +: 4];
        s_next.cfg.wl  = APB_REQ.pwdata[gdrw_pkg::CFG_WL_LSB +: 4];
        s_next.cfg.ilv = APB_REQ.pwdata[gdrw_pkg::CFG_ILV_BIT];
      end
      // an error raised in this same cycle survives the clear
      if (APB_REQ.paddr == gdrw_pkg::REG_STATUS && APB_REQ.pwdata[gdrw_pkg::STS_ERR_BIT]
          && !(s_next.cmd_err && !s_reg.cmd_err)) begin
        s_next.cmd_err = 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_reg           <= '0;
      s_reg.cfg.cl    <= gdrw_pkg::CFG_CL_RST;
      s_reg.cfg.wl    <= gdrw_pkg::CFG_WL_RST;
      s_reg.cfg.ilv   <= gdrw_pkg::CFG_ILV_RST;
      s_reg.dq_oe_n   <= 1'b1;
      s_reg.rstb_oe_n <= 1'b1;
      s_reg.odt       <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  gdrw_store u_store (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  assign DQ_OUT           = s_reg.dq_out;
  assign DQ_OE_N          = s_reg.dq_oe_n;
  assign READ_STROBE      = s_reg.rstb;
  assign READ_STROBE_OE_N = s_reg.rstb_oe_n;
  assign ODT_ON           = s_reg.odt;
  assign APB_RSP          = s_reg.apb;

  // ****************************************
  // checks
  // ****************************************
  default clocking dcb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  rd_latency_a: assert property ( // RULE6
    rise && rd_due |=> !DQ_OE_N && READ_STROBE == 4'h0)
    else $error("read data not started at cas latency");
  edge_align_a: assert property ( // RULE7
    $changed(DQ_OUT) |-> $past(tick) && !READ_STROBE_OE_N)
    else $error("read data moved off a clock edge");
  preamble_a: assert property ( // RULE8
    $fell(READ_STROBE_OE_N) |-> READ_STROBE == 4'hf && DQ_OE_N)
    else $error("read preamble not high");
  postamble_a: assert property ( // RULE8
    s_reg.rd_act && s_reg.rd_idx == gdrw_pkg::BURST_LAST |-> READ_STROBE == 4'hf)
    else $error("read postamble not on last element");
  release_a: assert property ( // RULE9
    $fell(s_reg.rd_act) |-> DQ_OE_N && READ_STROBE_OE_N)
    else $error("data lines held after burst");
  concat_a: assert property ( // RULE10
    rise && rd_due && s_reg.rd_act |=> s_reg.rd_idx == 2'h0 && !DQ_OE_N && !READ_STROBE_OE_N)
    else $error("concatenated read broke data flow");
  no_trunc_a: assert property ( // RULE11
    s_reg.rd_act && s_reg.rd_idx != gdrw_pkg::BURST_LAST |=> s_reg.rd_act)
    else $error("read burst cut short");
  odt_off_a: assert property ( // RULE12
    !DQ_OE_N |-> !ODT_ON)
    else $error("terminators on during read");
  lanes_a: assert property ( // RULE13
    !READ_STROBE_OE_N |-> READ_STROBE == 4'h0 || READ_STROBE == 4'hf)
    else $error("byte lane strobes disagree");
  wr_first_a: assert property ( // RULE17
    mem_we && s_reg.wr_idx == 2'h0 |-> ws_rise)
    else $error("first write element not on rising strobe");
  wr_ignore_a: assert property ( // RULE19
    mem_we |-> s_reg.wr_act)
    else $error("write data taken outside a burst");
  act_open_a: assert property ( // RULE24
    rise && decode(s_reg.cmd_s2) == gdrw_pkg::CMD_ACT && s_reg.cmd_s2.bank == 2'h0
    |=> s_reg.bank_open[0])
    else $error("active did not open bank");

  rd_start_c:  cover property (rise && rd_due && !s_reg.rd_act);
  rd_concat_c: cover property (rise && rd_due && s_reg.rd_act);
  wr_done_c:   cover property (mem_we && s_reg.wr_idx == gdrw_pkg::BURST_LAST);
  ap_close_c:  cover property ($fell(s_reg.ap_pend[0]) && !s_reg.bank_open[0]);

endmodule // gdrw_device

// file: hw/gdrw_pkg.sv
package gdrw_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS     = 10;
  // minimum_row_active_time, default of a plain speed grade
  localparam int unsigned ROW_ACTIVE_MIN_NS = 40;
  localparam logic [7:0]  ROW_ACTIVE_CYC    =
    8'((ROW_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************
  // geometry
  // ****************************************
  localparam int unsigned PIPE_DEPTH                = 16;
  localparam int unsigned COL_BITS                  = 3;
  localparam int unsigned ADDR_BITS                 = 2 + COL_BITS;
  localparam int unsigned MEM_WORDS                 = 1 << ADDR_BITS;
  localparam int unsigned AUTO_PRECHARGE_SELECT_BIT = 8;
  localparam logic [1:0]  BURST_LAST                = 2'h3;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_CONFIG   = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam int unsigned CFG_CL_LSB  = 0;
  localparam int unsigned CFG_WL_LSB  = 4;
  localparam int unsigned CFG_ILV_BIT = 8;
  localparam logic [3:0] CFG_CL_RST   = 4'h5;
  localparam logic [3:0] CFG_WL_RST   = 4'h3;
  localparam logic       CFG_ILV_RST  = 1'b0;
  localparam int unsigned STS_BANK_LSB = 0;
  localparam int unsigned STS_RD_BIT   = 4;
  localparam int unsigned STS_WR_BIT   = 5;
  localparam int unsigned STS_ERR_BIT  = 6;
  localparam int unsigned STS_AP_LSB   = 8;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_OTHER
  } gdrw_cmd_t;

  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bank;
    logic [11:0] addr;
  } gdrw_pins_t;

  typedef struct packed {
    logic                rd;
    logic                wr;
    logic                ap;
    logic [1:0]          bank;
    logic [COL_BITS-1:0] col;
  } gdrw_slot_t;

  typedef struct packed {
    logic [3:0] cl;
    logic [3:0] wl;
    logic       ilv;
  } gdrw_cfg_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } gdrw_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } gdrw_apb_rsp_t;

  typedef struct packed {
    logic [MEM_WORDS-1:0][31:0] word;
  } gdrw_mem_t;

endpackage

// file: hw/gdrw_store.sv
`timescale 1ns/1ps
module gdrw_store (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           we,
  input  wire logic [gdrw_pkg::ADDR_BITS-1:0] waddr,
  input  wire logic [31:0]                    wdata,
  input  wire logic [gdrw_pkg::ADDR_BITS-1:0] raddr,
  output logic      [31:0]                    rdata
);

  gdrw_pkg::gdrw_mem_t s_reg;
  gdrw_pkg::gdrw_mem_t s_next;

  // rows alias onto one small array: bank and low column bits index it
  always_comb begin
    s_next = s_reg;
    if (we) begin
      s_next.word[waddr] = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.word[raddr];

endmodule // gdrw_store

// file: verification/gdrw_ctl_model.sv
`timescale 1ns/1ps
// ****************
// controller side
// ****************
module gdrw_ctl_model (
  output logic                 CK,
  output gdrw_pkg::gdrw_pins_t CMD,
  output logic [31:0]          DQ_IN,
  output logic                 WRITE_STROBE
);
  int wl = 3;

  initial begin
    CK = 1'b0;
    CMD = {1'b1, 4'h7, 14'h0};
    DQ_IN = '0;
    WRITE_STROBE = 1'b0;
  end

  // a memory clock is never stopped
  always #62.5 CK = ~CK;

  // one command per call, so bank state and spacing follow the caller's order
  task automatic issue(input logic [3:0] code, input logic [1:0] b, input logic [11:0] a);
    @(negedge CK) CMD <= {1'b1, code, b, a};
    @(negedge CK) CMD <= {1'b1, 4'h7, 14'h0};
    if (code == 4'h3) repeat (2) @(negedge CK);
  endtask

  // data changes midway between strobe edges; the burst always runs whole
  task automatic wr(input logic [1:0] b, input logic [2:0] c, input logic ap,
                    input logic junk, input logic [3:0][31:0] d);
    issue(4'h4, b, {3'h0, ap, 5'h0, c});
    repeat (wl - 1) @(negedge CK);
    for (int i = 0; i < 4; i++) begin
      #31.25 DQ_IN = d[i];
      @(CK) WRITE_STROBE = ~WRITE_STROBE;
    end
    #31.25 DQ_IN = ~d[3];
    if (junk) repeat (2) @(CK) WRITE_STROBE = ~WRITE_STROBE;
  endtask
endmodule // gdrw_ctl_model

// file: verification/test_graphics_dram_row_read_write_ops.sv
`timescale 1ns/1ps
// ****************
// bench
// ****************
module test_graphics_dram_row_read_write_ops;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    ck, ws, oe_n, rs_oe_n, odt, err;
  logic [3:0]              rs;
  logic [31:0]             dq_in, dq_out, rd;
  logic [31:0]             mem [32];
  gdrw_pkg::gdrw_pins_t    cmd;
  gdrw_pkg::gdrw_apb_req_t req = '0;
  gdrw_pkg::gdrw_apb_rsp_t rsp;
  int                      miscompares = 0;
  int                      checked = 0;
  int                      cycles = 0;
  int                      rises = 0;

  always #5 clk = ~clk;
  always @(posedge ck) rises++;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  gdrw_device dut (.SYS_CLK(clk), .RST_N(rst_n), .CK(ck), .CMD(cmd), .DQ_IN(dq_in),
    .DQ_OUT(dq_out), .DQ_OE_N(oe_n), .READ_STROBE(rs), .READ_STROBE_OE_N(rs_oe_n),
    .WRITE_STROBE(ws), .ODT_ON(odt), .APB_REQ(req), .APB_RSP(rsp));
  gdrw_ctl_model ctl (.CK(ck), .CMD(cmd), .DQ_IN(dq_in), .WRITE_STROBE(ws));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    // only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    {err, rd} = {rsp.pslverr, rsp.prdata};
    req <= '0;
  endtask

  task automatic st(input logic [6:0] e);
    apb(1'b0, gdrw_pkg::REG_STATUS, '0);
    chk("status", rd[6:0], e);
  endtask

  task automatic wrt(input logic [1:0] b, input logic [2:0] c, input logic ap, input logic junk);
    logic [3:0][31:0] d;
    for (int i = 0; i < 4; i++) begin
      d[i] = 32'h11223344 * (i + 1) + 32'({b, c});
      mem[{b, c[2], c[1:0] + 2'(i)}] = d[i];
    end
    chk("odt before write", odt, 1);
    ctl.wr(b, c, ap, junk, d);
    repeat (4) @(posedge ck);
  endtask

  // elements are sampled two clocks after their strobe edge, clear of the edge that launched them
  task automatic rdchk(input logic [1:0] b, input logic [2:0] c, input logic ilv,
                       input int nb, input int cl);
    int r0, n, pre;
    logic [2:0] col;
    r0 = rises;
    n = 0;
    pre = 0;
    while (oe_n !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
      pre += int'(rs_oe_n === 1'b0 && rs === 4'hf);
    end
    chk("latency", rises - r0, cl);
    chk("preamble", pre inside {[5:8]}, 1);
    for (int i = 0; i < 4 * nb; i++) begin
      n = 0;
      while (i > 0 && rs === {4{~i[0]}} && n < 20) begin
        @(posedge clk);
        n++;
      end
      repeat (2) @(posedge clk);
      col = ilv ? c ^ {1'b0, i[1:0]} : {c[2], c[1:0] + i[1:0]};
      chk("data", dq_out, mem[{b, col}]);
      chk("strobe", rs, {4{i[0]}});
      chk("drive", {oe_n, rs_oe_n, odt}, 0);
    end
    repeat (14) @(posedge clk);
    chk("release", {oe_n, rs_oe_n, odt}, 3'h7);
  endtask

  task automatic t_regs;
    apb(1'b0, gdrw_pkg::REG_CONFIG, '0);
    chk("config", rd, 32'h35);
    apb(1'b0, 8'h08, '0);
    chk("unmapped", rd, 0);
    chk("slverr", err, 1);
  endtask

  task automatic t_rw;
    ctl.issue(4'h3, 2'h0, 12'h000);
    ctl.issue(4'h3, 2'h1, 12'h005);
    wrt(2'h0, 3'h0, 1'b0, 1'b1);
    st(7'h03);
    ctl.issue(4'h5, 2'h0, 12'h002);
    rdchk(2'h0, 3'h2, 1'b0, 1, 5);
  endtask

  task automatic t_seam;
    apb(1'b1, gdrw_pkg::REG_CONFIG, 32'h137);
    ctl.issue(4'h5, 2'h0, 12'h001);
    rdchk(2'h0, 3'h1, 1'b1, 1, 7);
    ctl.issue(4'h5, 2'h0, 12'h003);
    fork
      ctl.issue(4'h5, 2'h0, 12'h003);
    join_none
    rdchk(2'h0, 3'h3, 1'b1, 2, 7);
  endtask

  task automatic t_ap;
    ctl.issue(4'h3, 2'h0, 12'h000);
    st(7'h43);
    apb(1'b1, gdrw_pkg::REG_STATUS, 32'h40);
    st(7'h03);
    wrt(2'h1, 3'h4, 1'b1, 1'b0);
    st(7'h01);
    ctl.issue(4'h5, 2'h0, 12'h100);
    rdchk(2'h0, 3'h0, 1'b1, 1, 7);
    st(7'h00);
    ctl.issue(4'h3, 2'h1, 12'h000);
    ctl.issue(4'h5, 2'h1, 12'h004);
    rdchk(2'h1, 3'h4, 1'b1, 1, 7);
    ctl.issue(4'h3, 2'h2, 12'h000);
    ctl.issue(4'h2, 2'h0, 12'h100);
    st(7'h00);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_rw();
    t_seam();
    t_ap();
    end_sim();
  end
endmodule // test_graphics_dram_row_read_write_ops
